// File: common/rfnco_pkg.sv
package rfnco_pkg;
   // Clock and 12.5 ns event grid, in units of 100 ps
   localparam int unsigned CLK_PS    = 8000;
   localparam int unsigned STEP_PS   = 12500;
   localparam logic [7:0]  STEP_INC  = 8'(CLK_PS / 100);
   localparam logic [7:0]  STEP_WRAP = 8'(STEP_PS / 100);
   localparam int unsigned CYC_PER_MS = 1000000000 / CLK_PS;
   // Indicator timing
   localparam int unsigned BLINK_HALF_MS   = 250;
   localparam int unsigned FLICKER_HALF_MS = 25;
   localparam int unsigned ACTIVE_HOLD_MS  = 10;
   // Link word layout
   localparam int unsigned OP_LSB    = 28;
   localparam int unsigned SRC_LSB   = 26;
   localparam int unsigned AMP_LSB   = 14;
   localparam int unsigned OBS_BIT   = 4;
   localparam int unsigned RXEN_BIT  = 5;
   localparam int unsigned FREQ_SHL  = 4;
   localparam int unsigned PHASE_SHL = 18;
   // Opcodes
   localparam logic [2:0] OP_NOP       = 3'h0;
   localparam logic [2:0] OP_OBS_FREQ  = 3'h1;
   localparam logic [2:0] OP_SHIFT_FRQ = 3'h2;
   localparam logic [2:0] OP_LO_FREQ   = 3'h3;
   localparam logic [2:0] OP_AMP_PHASE = 3'h4;
   localparam logic [2:0] OP_PULSE     = 3'h5;
   localparam logic [2:0] OP_PATH      = 3'h6;
   // Oscillator sources for a pulse
   localparam logic [1:0] SRC_ZERO  = 2'h0;
   localparam logic [1:0] SRC_OBS   = 2'h1;
   localparam logic [1:0] SRC_SHIFT = 2'h2;
   // Board status pin positions
   localparam int unsigned PIN_PWR  = 0;
   localparam int unsigned PIN_DIAG = 1;
   localparam int unsigned PIN_REF  = 2;
   localparam int unsigned PIN_SRST = 3;
   localparam int unsigned PIN_RACK = 4;
   localparam int unsigned PIN_PEND = 5;
   typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_PULSE, PH_POST} rfnco_phase_t;
   typedef enum logic [2:0] {C_OFF, C_GREEN, C_YELLOW, C_RED, C_BLUE} rfnco_color_t;
endpackage

// File: core/rfnco_status_led.sv
module rfnco_status_led #(
   parameter int unsigned BLINK_CYC = 32'd31250000,
   parameter int unsigned FLICK_CYC = 32'd3125000
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    power_good,
   input  wire logic                    diag_mode,
   input  wire logic                    ref_ok,
   input  wire logic                    sync_reset,
   input  wire logic                    rack_busy,
   input  wire logic                    status_pending,
   input  wire logic [1:0]              ch_sync,
   input  wire logic [1:0]              ch_active,
   input  wire logic [1:0]              ch_fault,
   output rfnco_pkg::rfnco_color_t      status_led,
   output rfnco_pkg::rfnco_color_t [1:0] link_led
);
   typedef struct packed {
      logic [31:0]                   blink_cnt;
      logic                          blink;
      logic [31:0]                   flick_cnt;
      logic                          flick;
      rfnco_pkg::rfnco_color_t       stat;
      rfnco_pkg::rfnco_color_t [1:0] link;
   } rfnco_led_t;

   rfnco_led_t s_q;
   rfnco_led_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.blink_cnt = s_q.blink_cnt + 32'h1;
      if (s_q.blink_cnt >= BLINK_CYC - 1)
      begin
         s_d.blink_cnt = '0;
         s_d.blink = !s_q.blink;
      end
      s_d.flick_cnt = s_q.flick_cnt + 32'h1;
      if (s_q.flick_cnt >= FLICK_CYC - 1)
      begin
         s_d.flick_cnt = '0;
         s_d.flick = !s_q.flick;
      end
      s_d.link[0] = rfnco_pkg::C_OFF;
      s_d.link[1] = rfnco_pkg::C_OFF;
      if (!power_good)
         s_d.stat = rfnco_pkg::C_OFF;
      else if (diag_mode)
         s_d.stat = s_q.blink ? rfnco_pkg::C_GREEN : rfnco_pkg::C_OFF;
      else if (!ref_ok || sync_reset)
         s_d.stat = rfnco_pkg::C_BLUE;
      else if (|ch_fault)
      begin
         s_d.stat = rfnco_pkg::C_RED;
         for (int c = 0; c < 2; c++)
            s_d.link[c] = ch_fault[c] ? rfnco_pkg::C_RED : rfnco_pkg::C_GREEN;
      end
      else
      begin
         s_d.stat = rfnco_pkg::C_GREEN;
         if (rack_busy)
            s_d.stat = s_q.flick ? rfnco_pkg::C_YELLOW : rfnco_pkg::C_OFF;
         else if (status_pending)
            s_d.stat = rfnco_pkg::C_YELLOW;
         for (int c = 0; c < 2; c++)
         begin
            if (!ch_sync[c])
               s_d.link[c] = rfnco_pkg::C_OFF;
            else if (ch_active[c])
               s_d.link[c] = rfnco_pkg::C_YELLOW;
            else
               s_d.link[c] = rfnco_pkg::C_GREEN;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign status_led = s_q.stat;
   assign link_led   = s_q.link;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   power_dark_a: assert property (!power_good |=> status_led == rfnco_pkg::C_OFF
      && link_led == {rfnco_pkg::C_OFF, rfnco_pkg::C_OFF})
      else $error("indicators lit during power fault");
   diag_off_a: assert property (power_good && diag_mode |=> link_led ==
      {rfnco_pkg::C_OFF, rfnco_pkg::C_OFF} && status_led != rfnco_pkg::C_BLUE)
      else $error("link indicators lit in diagnostic mode");
   ref_blue_a: assert property (power_good && !diag_mode && !ref_ok
      |=> status_led == rfnco_pkg::C_BLUE)
      else $error("status not blue without reference");
endmodule

// File: core/rfnco_core.sv
module rfnco_core #(
   parameter int unsigned BLINK_CYC = rfnco_pkg::BLINK_HALF_MS * rfnco_pkg::CYC_PER_MS,
   parameter int unsigned FLICK_CYC = rfnco_pkg::FLICKER_HALF_MS * rfnco_pkg::CYC_PER_MS,
   parameter int unsigned ACT_CYC   = rfnco_pkg::ACTIVE_HOLD_MS * rfnco_pkg::CYC_PER_MS
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [1:0]               link_toggle,
   input  wire logic [1:0][15:0]         link_slot_data,
   input  wire logic [1:0]               link_sync,
   input  wire logic [5:0]               board_pins,
   input  wire logic [1:0][15:0]         shape_modulation_input,
   input  wire logic [1:0][15:0]         power_level_scaler,
   input  wire logic [15:0]              tx_pre_steps,
   input  wire logic [15:0]              tx_post_steps,
   input  wire logic                     err_clear,
   output logic      [1:0][15:0]         rf_sample,
   output logic      [15:0]              lo_sample,
   output logic      [1:0][3:0]          path_sel,
   output logic      [1:0]               amp_blank_n,
   output logic                          preamp_gate,
   output logic                          rx_gate,
   output logic                          dwell_en,
   output logic      [1:0]               ch_fault,
   output rfnco_pkg::rfnco_color_t       status_led,
   output rfnco_pkg::rfnco_color_t [1:0] link_led
);
   typedef struct packed {
      logic [1:0]                    tog1;
      logic [1:0]                    tog2;
      logic [1:0]                    tog3;
      logic [1:0][15:0]              dat1;
      logic [1:0][15:0]              dat2;
      logic [1:0]                    syn1;
      logic [1:0]                    syn2;
      logic [5:0]                    pin1;
      logic [5:0]                    pin2;
      logic [7:0]                    frac;
      logic                          tick;
      logic [1:0]                    half;
      logic [1:0][15:0]              hi;
      logic [1:0]                    wvalid;
      logic [1:0][31:0]              word;
      logic [1:0][31:0]              obs_freq;
      logic [1:0][31:0]              shift_sh;
      logic [1:0][31:0]              shift_act;
      logic [1:0][31:0]              lo_freq;
      logic [1:0][31:0]              acc1;
      logic [1:0][31:0]              acc2;
      logic [1:0][31:0]              acc3;
      logic [1:0][13:0]              amp_sh;
      logic [1:0][13:0]              amp;
      logic [1:0][13:0]              ph_sh;
      logic [1:0][13:0]              ph;
      logic [1:0][1:0]               src_sh;
      logic [1:0][1:0]               src;
      logic [1:0][15:0]              len;
      rfnco_pkg::rfnco_phase_t [1:0] st;
      logic [1:0][15:0]              cnt;
      logic [1:0][3:0]               path;
      logic [1:0]                    observe_channel;
      logic [1:0]                    rx_en;
      logic [1:0]                    fault;
      logic [1:0][31:0]              act_cnt;
      logic [1:0][15:0]              sample;
      logic [15:0]                   lo;
   } rfnco_core_t;

   rfnco_core_t        s_q;
   rfnco_core_t        s_d;
   logic        [2:0]  op;
   logic        [31:0] ph_ext;
   logic signed [15:0] raw;
   logic signed [30:0] p1;
   logic signed [31:0] p2;
   logic signed [32:0] p3;

   always_comb
   begin
      op     = '0;
      ph_ext = '0;
      raw    = '0;
      p1     = '0;
      p2     = '0;
      p3     = '0;
      s_d    = s_q;
      // Pins pass two flops before use
      s_d.tog1 = link_toggle;
      s_d.tog2 = s_q.tog1;
      s_d.tog3 = s_q.tog2;
      s_d.dat1 = link_slot_data;
      s_d.dat2 = s_q.dat1;
      s_d.syn1 = link_sync;
      s_d.syn2 = s_q.syn1;
      s_d.pin1 = board_pins;
      s_d.pin2 = s_q.pin1;
      s_d.tick = 1'b0;
      if (s_q.frac + rfnco_pkg::STEP_INC >= rfnco_pkg::STEP_WRAP)
      begin
         s_d.frac = s_q.frac + rfnco_pkg::STEP_INC - rfnco_pkg::STEP_WRAP;
         s_d.tick = 1'b1;
      end
      else
         s_d.frac = s_q.frac + rfnco_pkg::STEP_INC;
      s_d.wvalid = '0;
      if (err_clear)
         s_d.fault = '0;
      s_d.lo = '0;
      for (int c = 0; c < 2; c++)
      begin
         if (s_q.tog3[c] != s_q.tog2[c])
         begin
            if (!s_q.half[c])
            begin
               s_d.hi[c]   = s_q.dat2[c];
               s_d.half[c] = 1'b1;
            end
            else
            begin
               s_d.word[c]   = {s_q.hi[c], s_q.dat2[c]};
               s_d.wvalid[c] = 1'b1;
               s_d.half[c]   = 1'b0;
            end
         end
         if (!s_q.syn2[c])
            s_d.half[c] = 1'b0;
         // Free running phase accumulators
         s_d.acc1[c] = s_q.acc1[c] + s_q.obs_freq[c];
         s_d.acc2[c] = s_q.acc2[c] + s_q.shift_act[c];
         s_d.acc3[c] = s_q.acc3[c] + s_q.lo_freq[c];
         if (s_q.wvalid[c])
            s_d.act_cnt[c] = ACT_CYC;
         else if (s_q.act_cnt[c] != '0)
            s_d.act_cnt[c] = s_q.act_cnt[c] - 32'h1;
         op = s_q.word[c][30:rfnco_pkg::OP_LSB];
         if (s_q.wvalid[c] && ^s_q.word[c])
            s_d.fault[c] = 1'b1;
         else if (s_q.wvalid[c])
         begin
            unique case (op)
               rfnco_pkg::OP_NOP:
                  s_d.fault[c] = s_d.fault[c];
               rfnco_pkg::OP_OBS_FREQ:
                  s_d.obs_freq[c] = {s_q.word[c][27:0], 4'h0};
               rfnco_pkg::OP_SHIFT_FRQ:
                  s_d.shift_sh[c] = {s_q.word[c][27:0], 4'h0};
               rfnco_pkg::OP_LO_FREQ:
                  s_d.lo_freq[c] = {s_q.word[c][27:0], 4'h0};
               rfnco_pkg::OP_AMP_PHASE:
               begin
                  s_d.amp_sh[c] = s_q.word[c][27:rfnco_pkg::AMP_LSB];
                  s_d.ph_sh[c]  = s_q.word[c][13:0];
               end
               rfnco_pkg::OP_PULSE:
               begin
                  if (s_q.st[c] == rfnco_pkg::PH_IDLE)
                  begin
                     s_d.src_sh[c] = s_q.word[c][27:rfnco_pkg::SRC_LSB];
                     s_d.len[c]    = s_q.word[c][15:0];
                     s_d.cnt[c]    = tx_pre_steps;
                     s_d.st[c]     = rfnco_pkg::PH_PRE;
                  end
                  else
                     s_d.fault[c] = 1'b1;
               end
               rfnco_pkg::OP_PATH:
               begin
                  s_d.path[c]  = s_q.word[c][3:0];
                  s_d.observe_channel[c]   = s_q.word[c][rfnco_pkg::OBS_BIT];
                  s_d.rx_en[c] = s_q.word[c][rfnco_pkg::RXEN_BIT];
               end
               default:
                  s_d.fault[c] = 1'b1;
            endcase
         end
         if (s_q.tick)
         begin
            unique case (s_q.st[c])
               rfnco_pkg::PH_IDLE:
                  s_d.cnt[c] = s_d.cnt[c];
               rfnco_pkg::PH_PRE:
               begin
                  if (s_q.cnt[c] == '0)
                  begin
                     s_d.amp[c]       = s_q.amp_sh[c];
                     s_d.ph[c]        = s_q.ph_sh[c];
                     s_d.shift_act[c] = s_q.shift_sh[c];
                     s_d.src[c]       = s_q.src_sh[c];
                     s_d.cnt[c]       = s_q.len[c];
                     s_d.st[c]        = rfnco_pkg::PH_PULSE;
                  end
                  else
                     s_d.cnt[c] = s_q.cnt[c] - 16'h1;
               end
               rfnco_pkg::PH_PULSE:
               begin
                  if (s_q.cnt[c] == '0)
                  begin
                     s_d.cnt[c] = tx_post_steps;
                     s_d.st[c]  = rfnco_pkg::PH_POST;
                  end
                  else
                     s_d.cnt[c] = s_q.cnt[c] - 16'h1;
               end
               rfnco_pkg::PH_POST:
               begin
                  if (s_q.cnt[c] == '0)
                     s_d.st[c] = rfnco_pkg::PH_IDLE;
                  else
                     s_d.cnt[c] = s_q.cnt[c] - 16'h1;
               end
            endcase
         end
         raw = '0;
         if (s_q.st[c] == rfnco_pkg::PH_PULSE)
         begin
            ph_ext = {s_q.ph[c], 18'h0};
            if (s_q.src[c] == rfnco_pkg::SRC_OBS)
               raw = 16'($signed(s_q.acc1[c][31:16] + ph_ext[31:16]));
            else if (s_q.src[c] == rfnco_pkg::SRC_SHIFT)
               raw = 16'($signed(s_q.acc2[c][31:16] + ph_ext[31:16]));
         end
         p1 = 31'(raw * $signed({1'b0, s_q.amp[c]}));
         p2 = 32'($signed(p1[28:13]) * $signed(shape_modulation_input[c]));
         p3 = 33'($signed(p2[30:15]) * $signed({1'b0, power_level_scaler[c]}));
         s_d.sample[c] = p3[31:16];
         if (s_q.observe_channel[c])
            s_d.lo = s_q.acc3[c][31:16];
      end
      if (s_q.observe_channel == 2'h3 && s_q.wvalid != '0)
         s_d.fault = s_d.fault | s_q.wvalid;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign rf_sample = s_q.sample;
   assign lo_sample = s_q.lo;
   assign path_sel  = s_q.path;
   assign ch_fault  = s_q.fault;

   always_comb
   begin
      preamp_gate = 1'b0;
      rx_gate     = 1'b0;
      for (int c = 0; c < 2; c++)
      begin
         amp_blank_n[c] = (s_q.st[c] == rfnco_pkg::PH_IDLE);
         if (s_q.observe_channel[c] && s_q.st[c] != rfnco_pkg::PH_IDLE)
            preamp_gate = 1'b1;
         if (s_q.observe_channel[c] && s_q.rx_en[c] && s_q.st[c] == rfnco_pkg::PH_IDLE)
            rx_gate = 1'b1;
      end
      dwell_en = rx_gate && (s_q.syn2 & s_q.observe_channel) != '0;
   end

   rfnco_status_led #(
      .BLINK_CYC (BLINK_CYC),
      .FLICK_CYC (FLICK_CYC)
   ) u_led (
      .clk            (clk),
      .rst            (rst),
      .power_good     (s_q.pin2[rfnco_pkg::PIN_PWR]),
      .diag_mode      (s_q.pin2[rfnco_pkg::PIN_DIAG]),
      .ref_ok         (s_q.pin2[rfnco_pkg::PIN_REF]),
      .sync_reset     (s_q.pin2[rfnco_pkg::PIN_SRST]),
      .rack_busy      (s_q.pin2[rfnco_pkg::PIN_RACK]),
      .status_pending (s_q.pin2[rfnco_pkg::PIN_PEND]),
      .ch_sync        (s_q.syn2),
      .ch_active      ({s_q.act_cnt[1] != '0, s_q.act_cnt[0] != '0}),
      .ch_fault       (s_q.fault),
      .status_led     (status_led),
      .link_led       (link_led)
   );

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   for (genvar g = 0; g < 2; g++)
   begin : g_chk
      zero_output_a: assert property (s_q.st[g] != rfnco_pkg::PH_PULSE
         |=> rf_sample[g] == 16'h0000)
         else $error("output not null outside pulse");
      obs_kept_a: assert property (s_q.wvalid[g] && !(^s_q.word[g])
         && s_q.word[g][30:28] == rfnco_pkg::OP_SHIFT_FRQ
         |=> $stable(s_q.obs_freq[g]) && $stable(s_q.lo_freq[g]))
         else $error("shift touched observe oscillator");
      load_together_a: assert property ($changed(s_q.amp[g]) || $changed(s_q.ph[g])
         |-> s_q.st[g] == rfnco_pkg::PH_PULSE
         && $past(s_q.st[g]) == rfnco_pkg::PH_PRE)
         else $error("amplitude or phase loaded outside pulse start");
      path_cmd_a: assert property ($changed(path_sel[g])
         |-> $past(s_q.wvalid[g]))
         else $error("path changed without link command");
      pre_hold_a: assert property (s_q.st[g] == rfnco_pkg::PH_PRE && s_q.cnt[g] != '0
         |=> s_q.st[g] == rfnco_pkg::PH_PRE)
         else $error("pre-delay cut short");
      blank_pulse_a: assert property (s_q.st[g] == rfnco_pkg::PH_PULSE
         |-> !amp_blank_n[g])
         else $error("amplifier not blanked during pulse");
      parity_a: assert property (s_q.wvalid[g] && ^s_q.word[g]
         |=> ch_fault[g] [*2])
         else $error("parity fault not raised");
   end

   gate_obs_a: assert property (s_q.observe_channel == 2'h0
      |-> !preamp_gate && !rx_gate && !dwell_en)
      else $error("gating without observe channel");
   lo_obs_a: assert property (s_q.observe_channel == 2'h0 |=> lo_sample == 16'h0000)
      else $error("LO driven without observe channel");
endmodule

// File: tb/rfnco_link_model.sv
module rfnco_link_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [31:0] word,
   input  wire logic        bad_par,
   input  wire logic [1:0]  gap,
   output logic             toggle,
   output logic [15:0]      data,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] w;
   initial
   begin
      toggle = 1'b0;
      data = 16'h0000;
      busy = 1'b0;
   end
   always
   begin
      @(posedge clk);
      if (go && !busy)
      begin
         w = {(^word[30:0]) ^ bad_par, word[30:0]};
         busy <= 1'b1;
         for (int i = 0; i < 2; i++)
         begin
            data <= (i == 0) ? w[31:16] : w[15:0];
            repeat (3) @(posedge clk);
            toggle <= ~toggle;
            repeat (3) @(posedge clk);
            data <= ~data;
            repeat (gap + 1) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule

// File: tb/rfnco_core_tb_top.sv
module rfnco_core_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {int at; int id; logic [31:0] ex;} rfnco_note_t;
   localparam logic [2:0] OF = 3'(rfnco_pkg::C_OFF);
   localparam logic [2:0] GN = 3'(rfnco_pkg::C_GREEN);
   localparam logic [2:0] YL = 3'(rfnco_pkg::C_YELLOW);
   localparam logic [2:0] RD = 3'(rfnco_pkg::C_RED);
   localparam logic [2:0] BL = 3'(rfnco_pkg::C_BLUE);
   logic clk = 1'b0, rst = 1'b1, err_clear = 1'b0;
   logic [1:0] link_sync = 2'h0, go = 2'h0, bad = 2'h0;
   logic [5:0] board_pins = 6'h00;
   logic [1:0][15:0] shape = '0, power = '0;
   logic [15:0] pre_s = 16'h0000, post_s = 16'h0000;
   logic [31:0] wd [2] = '{32'h0, 32'h0};
   logic [1:0] gap [2] = '{2'h0, 2'h0};
   wire [1:0] link_toggle, busy;
   wire [1:0][15:0] link_slot_data;
   logic [1:0][15:0] rf_sample;
   logic [15:0] lo_sample;
   logic [1:0][3:0] path_sel;
   logic [1:0] amp_blank_n, ch_fault;
   logic preamp_gate, rx_gate, dwell_en;
   rfnco_pkg::rfnco_color_t status_led;
   rfnco_pkg::rfnco_color_t [1:0] link_led;
   rfnco_note_t q[$];
   int cyc = 0, miscompares = 0, n_checks = 0;
   always #4 clk = ~clk;
   rfnco_core #(.BLINK_CYC(8), .FLICK_CYC(4), .ACT_CYC(16)) i_dut (.clk(clk), .rst(rst),
      .link_toggle(link_toggle), .link_slot_data(link_slot_data), .link_sync(link_sync),
      .board_pins(board_pins), .shape_modulation_input(shape), .power_level_scaler(power),
      .tx_pre_steps(pre_s), .tx_post_steps(post_s), .err_clear(err_clear),
      .rf_sample(rf_sample), .lo_sample(lo_sample), .path_sel(path_sel),
      .amp_blank_n(amp_blank_n), .preamp_gate(preamp_gate), .rx_gate(rx_gate),
      .dwell_en(dwell_en), .ch_fault(ch_fault), .status_led(status_led), .link_led(link_led));
   for (genvar c = 0; c < 2; c++)
   begin : g_link
      rfnco_link_model i_link (.clk(clk), .go(go[c]), .word(wd[c]), .bad_par(bad[c]),
         .gap(gap[c]), .toggle(link_toggle[c]), .data(link_slot_data[c]), .busy(busy[c]));
   end
   function automatic logic [31:0] observe_channel(int id);
      case (id)
         0: return 32'(status_led);
         1: return 32'(link_led);
         2: return 32'(amp_blank_n);
         3: return 32'(path_sel);
         4: return 32'(ch_fault);
         5: return 32'(preamp_gate);
         6: return {30'h0, rf_sample[1] != 16'h0000, rf_sample[0] != 16'h0000};
         7: return 32'(lo_sample != 16'h0000);
         default: return {30'h0, rx_gate, dwell_en};
      endcase
   endfunction
   task automatic note(int id, logic [31:0] ex, int dly);
      q.push_back('{cyc + dly, id, ex});
   endtask
   task automatic send(int c, logic [31:0] w, logic b);
      wd[c] <= w;
      bad[c] <= b;
      gap[c] <= 2'($urandom_range(3));
      go[c] <= 1'b1;
      @(posedge clk);
      go[c] <= 1'b0;
      repeat (40) @(negedge clk) if (!busy[c] && cyc > 0) break;
      repeat (3) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic wait_low(int c);
      repeat (60) @(negedge clk) if (amp_blank_n[c] === 1'b0) break;
   endtask
   task automatic led(logic [5:0] p, logic [1:0] s, logic [2:0] st, logic [5:0] lk);
      board_pins <= p;
      link_sync <= s;
      repeat (6) @(posedge clk);
      note(0, 32'(st), 1);
      note(1, 32'(lk), 1);
      repeat (3) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always
   begin
      @(posedge clk);
      #1;
      cyc++;
      while (q.size() > 0 && q[0].at <= cyc)
      begin
         n_checks++;
         if (observe_channel(q[0].id) !== q[0].ex)
         begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, observe_channel(q[0].id), q[0].ex);
         end
         void'(q.pop_front());
      end
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
   initial
   begin
      int pre, post, len, ck, mid;
      logic [3:0] p4;
      void'($urandom(19094));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      note(2, 32'h3, 1);
      led(6'h00, 2'h3, OF, {OF, OF});
      led(6'h01, 2'h3, BL, {OF, OF});
      led(6'h0D, 2'h3, BL, {OF, OF});
      led(6'h05, 2'h3, GN, {GN, GN});
      led(6'h05, 2'h1, GN, {OF, GN});
      led(6'h25, 2'h3, YL, {GN, GN});
      board_pins <= 6'h0F;
      repeat (6) @(posedge clk);
      note(1, {OF, OF}, 1);
      led(6'h05, 2'h3, GN, {GN, GN});
      send(0, {1'b0, rfnco_pkg::OP_NOP, 28'h0}, 1'b0);
      note(1, {GN, YL}, 3);
      repeat (40) @(posedge clk);
      note(1, {GN, GN}, 1);
      $display("Indicator test done");
      p4 = 4'($urandom_range(15));
      shape <= {16'h7FFF, 16'h7FFF};
      power <= {16'hFFFF, 16'hFFFF};
      send(0, {1'b0, rfnco_pkg::OP_PATH, 22'h0, 2'h3, p4}, 1'b0);
      note(3, {24'h0, p4}, 3);
      note(8, 32'h3, 3);
      send(0, {1'b0, rfnco_pkg::OP_LO_FREQ, 28'h0123456}, 1'b0);
      repeat (4) @(posedge clk);
      note(7, 32'h1, 1);
      send(0, {1'b0, rfnco_pkg::OP_OBS_FREQ, 28'h0000001}, 1'b0);
      send(1, {1'b0, rfnco_pkg::OP_SHIFT_FRQ, 28'h0000001}, 1'b0);
      send(0, {1'b0, rfnco_pkg::OP_AMP_PHASE, 14'h1FFF, 14'h1000}, 1'b0);
      pre = $urandom_range(3);
      post = $urandom_range(3);
      len = $urandom_range(9, 2);
      pre_s <= 16'(pre);
      post_s <= 16'(post);
      ck = ((pre + len + post + 2) * 125) / 80;
      mid = ((pre * 125 + 79) / 80 + ((pre + len + 1) * 125) / 80 + 4) / 2;
      fork
         send(0, {1'b0, rfnco_pkg::OP_PULSE, rfnco_pkg::SRC_OBS, 10'h0, 16'(len)}, 1'b0);
         begin
            wait_low(0);
            note(5, 32'h1, 1);
            note(8, 32'h0, 1);
            note(6, 32'h1, mid);
            note(2, 32'h2, ck);
            note(2, 32'h3, ck + 3);
            note(8, 32'h3, ck + 4);
         end
      join
      repeat (ck + 12) @(posedge clk);
      fork
         send(1, {1'b0, rfnco_pkg::OP_PULSE, rfnco_pkg::SRC_ZERO, 10'h0, 16'h0003}, 1'b0);
         begin
            wait_low(1);
            note(5, 32'h0, 1);
            note(6, 32'h0, 4);
         end
      join
      repeat (40) @(posedge clk);
      $display("Pulse test done");
      send(1, {1'b0, rfnco_pkg::OP_PATH, 28'h0}, 1'b1);
      note(4, 32'h2, 3);
      note(0, 32'(RD), 3);
      note(1, {RD, GN}, 3);
      repeat (6) @(posedge clk);
      err_clear <= 1'b1;
      @(posedge clk);
      err_clear <= 1'b0;
      note(4, 32'h0, 3);
      send(0, {1'b0, 3'h7, 28'h0}, 1'b0);
      note(4, 32'h1, 3);
      repeat (10) @(posedge clk);
      $display("Fault test done");
      print_verdict();
   end
endmodule
